//--- hw/pdag_pkg.sv
// Package: constants and types for the paged data address generator
package pdag_pkg;
	localparam int PAGE_W = 10;
	localparam int EA_W   = 16;
	localparam int PA_W   = 24;
	localparam int PAGE_MSB   = 9;
	localparam int EA_MSB     = 15;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 10'h001;
	localparam logic [PAGE_W-1:0] PAGE_ZERO  = 10'h000;
	localparam logic [PAGE_W-1:0] PAGE_LAST  = 10'h3FF;
	localparam logic [PAGE_W-1:0] PAGE_FIRST = 10'h001;
	localparam logic [PAGE_W-1:0] PAGE_PS0   = 10'h200;
	// Largest pointer step that still carries the page forward
	localparam logic [EA_W-1:0]   SMALL_STEP = 16'h000A;
	// APB register byte addresses
	localparam logic [11:0] ADDR_PAGE   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_MASK   = 12'h008;
	localparam logic [11:0] ADDR_LAST   = 12'h00C;
	// Status and mask bit positions
	localparam int ST_TRAP  = 0;
	localparam int ST_WRERR = 1;
	localparam int ST_OVF   = 2;
	localparam int ST_UNF   = 3;
	localparam int ST_W     = 4;
	typedef enum logic [2:0] {
		PDAG_MODE_PLAIN  = 3'h0,
		PDAG_MODE_PRE    = 3'h1,
		PDAG_MODE_POST   = 3'h2,
		PDAG_MODE_OFFSET = 3'h3,
		PDAG_MODE_MODULO = 3'h4,
		PDAG_MODE_BITREV = 3'h5
	} pdag_mode_t;
endpackage : pdag_pkg

//--- hw/pdag_top.sv
// Paged data address generator with APB register access
// Notes on behaviour
// - Page bit 9 and address bit 15 set give page[8:0] over address[14:0].
// - Each page selects one 32-Kbyte window; up to 16 Mbytes overall.
// - Pages 0x200 and above map program space; reads only, writes refused.
// - Page carry only for paged start address with pre/post modify, not offset.
// - Address calculation clears bit 15 on window overflow or underflow.
// - Overflow increments page and sets bit 15.
// - Underflow decrements page and sets bit 15.
// - Offset, modulo, bit-reversed modes wrap in page: set bit 15, page kept.
// - Overflow from page 0x3FF keeps page, bit 15 stays clear.
// - Underflow from 0x001 or 0x200 keeps page, bit 15 clear, base space.
// - Paged access with page 0x000 raises an address error trap.
// - Large offsets do not carry the page forward.
// - Reset sets page register to 0x001.
// - Software write of zero to page register is ignored.
// - Addresses with bit 15 clear always reach base data space.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
module pdag_top
	import pdag_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    acc_valid,
	input  wire logic                    acc_write,
	input  wire logic [2:0]              acc_mode,
	input  wire logic [pdag_pkg::EA_W-1:0] base_address,
	input  wire logic [pdag_pkg::EA_W-1:0] effective_address,
	input  wire logic [pdag_pkg::EA_W-1:0] step_size,
	output logic                         out_valid,
	output logic                         out_program_space,
	output logic [pdag_pkg::PA_W-1:0]    out_address,
	output logic                         address_error_trap,
	output logic                         irq
);
	import pdag_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [PAGE_W-1:0] data_read_page_select_q;
	logic [ST_W-1:0]   status_q;
	logic [ST_W-1:0]   mask_q;
	logic [PA_W-1:0]   out_address_q;
	logic              out_valid_q;
	logic              out_ps_q;
	logic              trap_q;

	logic              apb_wr;
	logic              apb_rd;
	logic              in_window;
	logic              modify_mode;
	logic              wrap_mode;
	logic              small_step;
	logic              overflow;
	logic              underflow;
	logic [PAGE_W-1:0] page_d;
	logic [EA_W-1:0]   ea_d;
	logic              trap_d;
	logic              wr_refused;
	logic [ST_W-1:0]   events;
	pdag_mode_t        mode;

	assign mode   = pdag_mode_t'(acc_mode);
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Boundary detection: a carry out of the window shows as bit 15 cleared
	assign in_window   = base_address[EA_MSB];
	assign modify_mode = (mode == PDAG_MODE_PRE) || (mode == PDAG_MODE_POST);
	assign wrap_mode   = (mode == PDAG_MODE_OFFSET) || (mode == PDAG_MODE_MODULO)
		|| (mode == PDAG_MODE_BITREV);
	// Step magnitude; either sign counts
	assign small_step  = (step_size <= SMALL_STEP) || ((~step_size + 16'h0001) <= SMALL_STEP);
	// Bit 15 is lost on a crossing, so the direction shows in the low 15 bits only;
	// a step of half the window or more cannot be told apart, hence no carry for it
	assign overflow    = in_window && !effective_address[EA_MSB]
		&& (effective_address[EA_MSB-1:0] < base_address[EA_MSB-1:0]);
	assign underflow   = in_window && !effective_address[EA_MSB]
		&& (effective_address[EA_MSB-1:0] >= base_address[EA_MSB-1:0]);

	always_comb begin
		page_d = data_read_page_select_q;
		ea_d   = effective_address;
		if (acc_valid && (overflow || underflow)) begin
			if (wrap_mode) begin
				ea_d[EA_MSB] = 1'b1;
			end else if (modify_mode && small_step) begin
				if (overflow) begin
					if (data_read_page_select_q != PAGE_LAST) begin
						page_d         = data_read_page_select_q + 10'h001;
						ea_d[EA_MSB]   = 1'b1;
					end
				end else if ((data_read_page_select_q != PAGE_FIRST)
					&& (data_read_page_select_q != PAGE_PS0)) begin
					page_d       = data_read_page_select_q - 10'h001;
					ea_d[EA_MSB] = 1'b1;
				end
			end
		end
	end

	// Paged access needs a nonzero page; bit 15 clear never traps
	assign trap_d     = acc_valid && ea_d[EA_MSB] && (page_d == PAGE_ZERO);
	assign wr_refused = acc_valid && acc_write && ea_d[EA_MSB] && page_d[PAGE_MSB];

	////////////////////////////////////////////////////////////////////////
	// Page register; the access path wins over a software write in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_read_page_select_q <= PAGE_RESET;
		end else if (acc_valid && (page_d != data_read_page_select_q)) begin
			data_read_page_select_q <= page_d;
		end else if (apb_wr && (paddr == ADDR_PAGE) && (pwdata[PAGE_W-1:0] != PAGE_ZERO)) begin
			data_read_page_select_q <= pwdata[PAGE_W-1:0];
		end
	end

	// Output address: program window concatenates page over 15 address bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_address_q <= '0;
			out_ps_q      <= 1'b0;
			out_valid_q   <= 1'b0;
			trap_q        <= 1'b0;
		end else begin
			out_valid_q <= acc_valid && !trap_d && !wr_refused;
			trap_q      <= trap_d;
			if (acc_valid) begin
				if (ea_d[EA_MSB] && page_d[PAGE_MSB]) begin
					out_address_q <= {page_d[PAGE_MSB-1:0], ea_d[EA_MSB-1:0]};
					out_ps_q      <= 1'b1;
				end else if (ea_d[EA_MSB]) begin
					out_address_q <= {page_d[PAGE_MSB-1:0], ea_d[EA_MSB-1:0]};
					out_ps_q      <= 1'b0;
				end else begin
					out_address_q <= {8'h00, ea_d};
					out_ps_q      <= 1'b0;
				end
			end
		end
	end

	assign out_valid          = out_valid_q;
	assign out_program_space  = out_ps_q;
	assign out_address        = out_address_q;
	assign address_error_trap = trap_q;

	////////////////////////////////////////////////////////////////////////
	// Sticky status: a set in the clearing cycle wins
	always_comb begin
		events           = '0;
		events[ST_TRAP]  = trap_d;
		events[ST_WRERR] = wr_refused;
		events[ST_OVF]   = acc_valid && overflow;
		events[ST_UNF]   = acc_valid && underflow;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_q <= '0;
		end else if (apb_wr && (paddr == ADDR_STATUS)) begin
			status_q <= (status_q & ~pwdata[ST_W-1:0]) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (apb_wr && (paddr == ADDR_MASK)) begin
			mask_q <= pwdata[ST_W-1:0];
		end
	end

	assign irq = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////////////
	// Read data registered in the setup phase; unmapped reads zero with error
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_PAGE:   prdata <= {22'h000000, data_read_page_select_q};
				ADDR_STATUS: prdata <= {28'h0000000, status_q};
				ADDR_MASK:   prdata <= {28'h0000000, mask_q};
				ADDR_LAST:   prdata <= {8'h00, out_address_q};
				default:     prdata <= '0;
			endcase
		end
	end

	always_comb begin
		pslverr = 1'b0;
		if (psel && penable) begin
			pslverr = !((paddr == ADDR_PAGE) || (paddr == ADDR_STATUS)
				|| (paddr == ADDR_MASK) || ((paddr == ADDR_LAST) && apb_rd));
		end
	end
endmodule : pdag_top

//--- dv/pdag_cpu_model.sv
// CPU address stage model issuing one access at a time
`timescale 1ns/100ps
module pdag_cpu_model
	import pdag_pkg::*;
(
	input  wire logic                     clk,
	output logic                          acc_valid,
	output logic                          acc_write,
	output logic [2:0]                    acc_mode,
	output logic [pdag_pkg::EA_W-1:0]     base_address,
	output logic [pdag_pkg::EA_W-1:0]     effective_address,
	output logic [pdag_pkg::EA_W-1:0]     step_size
);
	initial begin
		acc_valid = 1'b0;
		{acc_write, acc_mode, base_address, effective_address, step_size} = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Caller supplies the address with bit 15 already cleared on a window crossing
	task automatic issue(input logic w, input logic [2:0] m, input logic [15:0] b, e, s);
		@(posedge clk);
		acc_valid         <= 1'b1;
		acc_write         <= w;
		acc_mode          <= m;
		base_address      <= b;
		effective_address <= e;
		step_size         <= s;
		@(posedge clk);
		acc_valid <= 1'b0;
		// Idle address buses carry inverted values so stale data never looks valid
		{base_address, effective_address} <= ~{b, e};
	endtask : issue
endmodule : pdag_cpu_model

//--- dv/pdag_top_asserts.sv
// Concurrent checks on the address generator ports
`timescale 1ns/100ps
module pdag_top_asserts
	import pdag_pkg::*;
(
	input wire logic                      clk,
	input wire logic                      rst_n,
	input wire logic                      acc_valid,
	input wire logic                      acc_write,
	input wire logic [2:0]                acc_mode,
	input wire logic [pdag_pkg::EA_W-1:0] effective_address,
	input wire logic                      out_valid,
	input wire logic                      out_program_space,
	input wire logic [pdag_pkg::PA_W-1:0] out_address,
	input wire logic                      address_error_trap
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_base_space_pass: assert property (acc_valid && !effective_address[15] && acc_mode == 3'h0
		|=> out_valid && out_address == {8'h00, $past(effective_address)}) else $error("base pass");
	a_ps_read_only: assert property (acc_valid && acc_write
		|=> !(out_valid && out_program_space)) else $error("program write passed");
	a_trap_no_out: assert property (address_error_trap |-> !out_valid) else $error("trap with out");
	a_trap_after_req: assert property (address_error_trap |-> $past(acc_valid)) else $error("trap");
	a_out_needs_req: assert property (out_valid |-> $past(acc_valid)) else $error("stray out");
	a_ps_needs_paged: assert property (acc_valid && !effective_address[15] && acc_mode == 3'h0
		|=> !out_program_space) else $error("program flag in base");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n
		|=> !out_valid && out_address == 24'h000000) else $error("reset outputs");
	a_paged_read_ans: assert property (acc_valid && acc_mode == 3'h0 && effective_address[15]
		&& !acc_write |=> out_valid || address_error_trap) else $error("no answer");
endmodule : pdag_top_asserts
bind pdag_top pdag_top_asserts u_chk (.clk, .rst_n, .acc_valid, .acc_write, .acc_mode,
	.effective_address, .out_valid, .out_program_space, .out_address, .address_error_trap);

//--- dv/pdag_top_tb.sv
// Register and address sequence bench for the address generator
`timescale 1ns/100ps
module pdag_top_tb;
	import pdag_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, irq;
	logic out_valid, out_program_space, address_error_trap, acc_valid, acc_write;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  acc_mode;
	logic [15:0] base_address, effective_address, step_size;
	logic [23:0] out_address;
	logic [9:0]  pg;
	int          fails, samples_checked;
	pdag_top u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .acc_valid, .acc_write, .acc_mode, .base_address, .effective_address,
		.step_size, .out_valid, .out_program_space, .out_address, .address_error_trap, .irq);
	pdag_cpu_model u_cpu (.clk, .acc_valid, .acc_write, .acc_mode, .base_address,
		.effective_address, .step_size);
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checked %0d wrong %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fails++;
			tally_and_finish();
		end
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", rd, e);
	endtask : rdchk
	task automatic acc(input logic w, input logic [2:0] m, input logic [15:0] b, e, s,
		input logic v, input logic [23:0] a);
		u_cpu.issue(w, m, b, e, s);
		#1;
		chk("valid", out_valid, v);
		if (v)
			chk("address", out_address, a);
	endtask : acc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(ADDR_PAGE, 32'h001);
		apb(1'b1, ADDR_PAGE, 32'h0);
		rdchk(ADDR_PAGE, 32'h001);
		rdchk(12'h010, 32'h0);
		chk("slverr", err, 1'b1);
		apb(1'b1, ADDR_PAGE, 32'h2FF);
		acc(1'b0, 3'h2, 16'hFFFE, 16'h0000, 16'h0002, 1'b1, 24'h800000);
		rdchk(ADDR_PAGE, 32'h300);
		acc(1'b0, 3'h1, 16'h8000, 16'h7FFE, 16'hFFFE, 1'b1, 24'h7FFFFE);
		rdchk(ADDR_PAGE, 32'h2FF);
		apb(1'b1, ADDR_PAGE, 32'hFFFF);
		rdchk(ADDR_PAGE, 32'h3FF);
		acc(1'b0, 3'h2, 16'hFFFE, 16'h0000, 16'h0002, 1'b1, 24'h000000);
		rdchk(ADDR_PAGE, 32'h3FF);
		for (int i = 0; i < 2; i++) begin
			pg = i ? 10'h001 : 10'h200;
			apb(1'b1, ADDR_PAGE, pg);
			acc(1'b0, 3'h1, 16'h8000, 16'h7FFE, 16'hFFFE, 1'b1, 24'h007FFE);
			rdchk(ADDR_PAGE, pg);
		end
		pg = 10'h123;
		apb(1'b1, ADDR_PAGE, pg);
		for (int m = 3; m < 6; m++)
			acc(1'b0, 3'(m), 16'hFFFE, 16'h0000, 16'h0002, 1'b1, {pg[8:0], 15'h0});
		acc(1'b0, 3'h0, 16'h1234, 16'h1234, 16'h0, 1'b1, 24'h001234);
		acc(1'b0, 3'h2, 16'hFFF0, 16'h00F0, 16'h0100, 1'b1, 24'h0000F0);
		rdchk(ADDR_PAGE, pg);
		apb(1'b1, ADDR_PAGE, 32'h300);
		acc(1'b0, 3'h0, 16'h8005, 16'h8005, 16'h0, 1'b1, 24'h800005);
		chk("program", out_program_space, 1'b1);
		rdchk(ADDR_LAST, 32'h800005);
		apb(1'b1, ADDR_STATUS, 32'hF);
		acc(1'b1, 3'h0, 16'h8005, 16'h8005, 16'h0, 1'b0, 24'h0);
		chk("irq masked", irq, 1'b0);
		apb(1'b1, ADDR_MASK, 32'h2);
		#1;
		chk("irq", irq, 1'b1);
		rdchk(ADDR_MASK, 32'h2);
		rdchk(ADDR_STATUS, 32'h2);
		apb(1'b1, ADDR_STATUS, 32'h2);
		#1;
		chk("irq cleared", irq, 1'b0);
		// Second reset in mid-run must bring the page back to its first value
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(ADDR_PAGE, 32'h001);
		rdchk(ADDR_STATUS, 32'h0);
		tally_and_finish();
	end
endmodule : pdag_top_tb
